// file: content_protect_status_irq_tb.sv
`timescale 1ns/100ps

module content_protect_status_irq_tb;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic chan_err = 1'b0;
  logic pin_n = 1'b1;
  logic lock = 1'b0;
  logic hotplug = 1'b0;
  logic found = 1'b0;
  logic rep = 1'b0;
  logic lost_evt = 1'b0;
  logic ind_evt = 1'b0;
  logic kl_rdy, kv_rdy, pass_evt, prot_en, a_start, a_stop, a_hold, irq_out;
  int fails = 0;
  int checked = 0;
  int seed = 32'h214d;
  logic [7:0] exp_q[$];
  bit care_q[$];
  string name_q[$];
  logic [7:0] v;
  logic [7:0] exp_v;

  always #5 core_clk = ~core_clk;

  cpsi_status_irq dut_u (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .control_channel_error(chan_err),
    .downstream_irq_pin_n(pin_n), .downstream_lock_seen(lock),
    .downstream_hotplug(hotplug), .receiver_found(found), .is_repeater(rep),
    .key_list_ready(kl_rdy), .key_vector_ready(kv_rdy), .auth_pass_evt(pass_evt),
    .auth_lost_evt(lost_evt), .indirect_done_evt(ind_evt), .protect_enabled(prot_en),
    .auth_start(a_start), .auth_stop(a_stop), .auth_hold(a_hold), .irq_out(irq_out));

  cpsi_far_model far_u (.core_clk(core_clk), .auth_start(a_start), .auth_hold(a_hold),
    .is_repeater(rep), .key_vector_ready(kv_rdy), .key_list_ready(kl_rdy),
    .auth_pass_evt(pass_evt));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] e);
    checked++;
    if (seen !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, seen);
    end
  endtask : chk

  task automatic close_out();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input bit c, input string n);
    exp_q.push_back(e);
    care_q.push_back(c);
    name_q.push_back(n);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask : rd

  task automatic wait_irq();
    int k;
    k = 0;
    while (irq_out !== 1'b1 && k < 60) begin
      @(posedge core_clk);
      k++;
    end
    chk("irq_out", {7'h00, irq_out}, 8'h01);
  endtask : wait_irq

  // Read results are taken off the queue in issue order
  always @(negedge core_clk) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("Error rdata expected none seen %h", reg_rdata);
      end else begin
        exp_v = exp_q.pop_front();
        if (care_q.pop_front()) chk(name_q.pop_front(), reg_rdata, exp_v);
        else void'(name_q.pop_front());
      end
    end
  end

  initial begin
    #400000;
    fails++;
    close_out();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    rd(cpsi_pkg::ADDR_IEN, cpsi_pkg::RST_IEN, 1, "ien");
    rd(cpsi_pkg::ADDR_CTL, 8'h00, 1, "ctl");
    rd(8'hc5, 8'h00, 1, "unmapped");
    wr(cpsi_pkg::ADDR_STS, 8'hff);
    rd(cpsi_pkg::ADDR_STS, 8'h40, 1, "sts");
    repeat (4) begin
      v = 8'($random(seed));
      wr(cpsi_pkg::ADDR_IEN, v);
      rd(cpsi_pkg::ADDR_IEN, v, 1, "ien");
    end
    wr(cpsi_pkg::ADDR_IEN, 8'h00);
    $display("test registers done");

    @(posedge core_clk);
    chan_err <= 1'b1;
    hotplug <= 1'b1;
    pin_n <= 1'b0;
    lock <= 1'b1;
    found <= 1'b1;
    @(posedge core_clk);
    chan_err <= 1'b0;
    hotplug <= 1'b0;
    repeat (2) @(posedge core_clk);
    rd(cpsi_pkg::ADDR_STS, 8'hb8, 1, "sts");
    rd(cpsi_pkg::ADDR_STS, 8'h28, 1, "sts");
    pin_n <= 1'b1;
    lock <= 1'b0;
    found <= 1'b0;
    rd(cpsi_pkg::ADDR_ISR, 8'h00, 1, "isr");
    $display("test status done");

    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'h80 : (i == 1) ? 8'h04 : 8'h20;
      wr(cpsi_pkg::ADDR_IEN, v | 8'h01);
      @(posedge core_clk);
      ind_evt <= (i == 0);
      lost_evt <= (i == 1);
      pin_n <= (i != 2);
      @(posedge core_clk);
      ind_evt <= 1'b0;
      lost_evt <= 1'b0;
      wait_irq();
      pin_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd(cpsi_pkg::ADDR_ISR, v | 8'h01, 1, "isr");
    end
    repeat (2) @(posedge core_clk);
    chk("irq_out", {7'h00, irq_out}, 8'h00);
    wr(cpsi_pkg::ADDR_IEN, 8'h04);
    @(posedge core_clk);
    lost_evt <= 1'b1;
    @(posedge core_clk);
    lost_evt <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("irq_out", {7'h00, irq_out}, 8'h00);
    rd(cpsi_pkg::ADDR_ISR, 8'h05, 1, "isr");
    $display("test sources done");

    wr(cpsi_pkg::ADDR_CFG, 8'h02);
    rd(cpsi_pkg::ADDR_CFG, 8'h02, 1, "cfg");
    wr(cpsi_pkg::ADDR_IEN, 8'h41);
    found <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk("irq_out", {7'h00, irq_out}, 8'h00);
    lock <= 1'b1;
    wait_irq();
    found <= 1'b0;
    lock <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd(cpsi_pkg::ADDR_ISR, 8'h41, 1, "isr");
    wr(cpsi_pkg::ADDR_IEN, 8'h00);
    rd(cpsi_pkg::ADDR_ISR, 8'h00, 1, "isr");
    $display("test receiver done");

    wr(cpsi_pkg::ADDR_IEN, 8'h0b);
    wr(cpsi_pkg::ADDR_CTL, 8'h01);
    @(negedge core_clk);
    chk("enabled", {7'h00, prot_en}, 8'h01);
    chk("start", {7'h00, a_start}, 8'h01);
    rd(cpsi_pkg::ADDR_CTL, 8'h01, 1, "ctl");
    wait_irq();
    rd(cpsi_pkg::ADDR_ISR, 8'h09, 1, "isr");
    rd(cpsi_pkg::ADDR_STS, 8'h42, 1, "sts");
    chk("hold", {7'h00, a_hold}, 8'h01);
    wr(cpsi_pkg::ADDR_CTL, 8'h10);
    wait_irq();
    rd(cpsi_pkg::ADDR_ISR, 8'h03, 1, "isr");
    rd(cpsi_pkg::ADDR_STS, 8'h41, 1, "sts");
    wr(cpsi_pkg::ADDR_CTL, 8'h00);
    rd(cpsi_pkg::ADDR_STS, 8'h41, 1, "sts");
    rd(cpsi_pkg::ADDR_CTL, 8'h01, 1, "ctl");
    $display("test receiver auth done");

    @(posedge core_clk);
    rep <= 1'b1;
    wr(cpsi_pkg::ADDR_IEN, 8'h13);
    wr(cpsi_pkg::ADDR_CTL, 8'h01);
    rd(cpsi_pkg::ADDR_STS, 8'h40, 1, "sts");
    wait_irq();
    rd(cpsi_pkg::ADDR_ISR, 8'h11, 1, "isr");
    rd(cpsi_pkg::ADDR_STS, 8'h46, 1, "sts");
    chk("hold", {7'h00, a_hold}, 8'h01);
    wr(cpsi_pkg::ADDR_CTL, 8'h20);
    wait_irq();
    rd(cpsi_pkg::ADDR_ISR, 8'h03, 1, "isr");
    rd(cpsi_pkg::ADDR_STS, 8'h43, 1, "sts");
    wr(cpsi_pkg::ADDR_CTL, 8'h80);
    @(negedge core_clk);
    chk("enabled", {7'h00, prot_en}, 8'h00);
    chk("stop", {7'h00, a_stop}, 8'h01);
    wr(cpsi_pkg::ADDR_CTL, 8'h01);
    @(negedge core_clk);
    chk("start", {7'h00, a_start}, 8'h01);
    wr(cpsi_pkg::ADDR_CTL, 8'h02);
    @(negedge core_clk);
    chk("enabled", {7'h00, prot_en}, 8'h00);
    chk("stop", {7'h00, a_stop}, 8'h01);
    $display("test repeater auth done");

    repeat (4) @(posedge core_clk);
    chk("pending reads", 8'(exp_q.size()), 8'h00);
    close_out();
  end
endmodule : content_protect_status_irq_tb

// file: cpsi_far_model.sv
`timescale 1ns/100ps

module cpsi_far_model (
  input wire logic core_clk, // Core clock
  input wire logic auth_start, // Start or restart pulse from device
  input wire logic auth_hold, // Pause request from device
  input wire logic is_repeater, // Far side acts as a repeater
  output logic key_vector_ready, // Receiver key read pulse
  output logic key_list_ready, // Key list loaded pulse
  output logic auth_pass_evt // Authentication passed pulse
);
  // ****************************************************************
  // Downstream authentication sequence
  // ****************************************************************
  initial begin
    key_vector_ready = 1'b0;
    key_list_ready = 1'b0;
    auth_pass_evt = 1'b0;
    forever begin
      @(negedge core_clk);
      if (auth_start === 1'b1) begin
        repeat (3) @(posedge core_clk);
        key_vector_ready <= 1'b1;
        @(posedge core_clk);
        key_vector_ready <= 1'b0;
        repeat (3) @(posedge core_clk);
        // Non-repeater stalls until the host accepts the receiver key; a repeater gets no hold here
        while (auth_hold === 1'b1) @(negedge core_clk);
        if (is_repeater === 1'b1) begin
          @(posedge core_clk);
          key_list_ready <= 1'b1;
          @(posedge core_clk);
          key_list_ready <= 1'b0;
          repeat (3) @(posedge core_clk);
          // Stall until the host accepts the key list
          while (auth_hold === 1'b1) @(negedge core_clk);
        end
        @(posedge core_clk);
        auth_pass_evt <= 1'b1;
        @(posedge core_clk);
        auth_pass_evt <= 1'b0;
      end
    end
  end
endmodule : cpsi_far_model

// file: cpsi_irq_bank.sv
`timescale 1ns/100ps

module cpsi_irq_bank (
  input wire logic core_clk, // Core clock
  input wire logic srst, // Synchronous reset
  cpsi_irq_if.bank ib // Conditions in, pending and irq out
);

  logic [7:1] pend_q;
  logic irq_q;

  // ****************************************************************
  // Sticky pending bits, set wins over clear
  // ****************************************************************
  for (genvar gi = 1; gi <= 7; gi++) begin : g_src
    always_ff @(posedge core_clk) begin
      if (srst) begin
        pend_q[gi] <= 1'b0;
      end else if (ib.cond[gi] && ib.enable[gi]) begin
        pend_q[gi] <= 1'b1;
      end else if (ib.clear) begin
        pend_q[gi] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Interrupt line to the host
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= ib.enable[cpsi_pkg::IRQ_GLOBAL] && (|pend_q);
    end
  end

  assign ib.pending = pend_q;
  assign ib.irq = irq_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_pend_needs_en: assert property (@(posedge core_clk) disable iff (srst)
    (pend_q & ~$past(pend_q)) != 7'h00 |-> ($past(ib.cond & ib.enable[7:1])) != 7'h00)
    else $error("pending bit set without enabled condition");

  a_global_gate: assert property (@(posedge core_clk) disable iff (srst)
    ib.irq |-> $past(ib.enable[cpsi_pkg::IRQ_GLOBAL]) && $past(|pend_q))
    else $error("irq driven without global enable or pending source");

  a_pend_hold: assert property (@(posedge core_clk) disable iff (srst)
    pend_q[cpsi_pkg::IRQ_AUTH_PASS] && !ib.clear |=> pend_q[cpsi_pkg::IRQ_AUTH_PASS])
    else $error("pending bit dropped without service");

endmodule : cpsi_irq_bank

// file: cpsi_irq_if.sv
`timescale 1ns/100ps

interface cpsi_irq_if;
  logic [7:1] cond;
  logic [7:0] enable;
  logic clear;
  logic [7:1] pending;
  logic irq;

  modport bank (
    input cond,
    input enable,
    input clear,
    output pending,
    output irq
  );

  modport ctrl (
    output cond,
    output enable,
    output clear,
    input pending,
    input irq
  );
endinterface : cpsi_irq_if

// file: cpsi_pkg.sv
package cpsi_pkg;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_CFG = 8'hc2;
  localparam logic [7:0] ADDR_CTL = 8'hc3;
  localparam logic [7:0] ADDR_STS = 8'hc4;
  localparam logic [7:0] ADDR_IEN = 8'hc6;
  localparam logic [7:0] ADDR_ISR = 8'hc7;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_STS = 8'h00;
  localparam logic [7:0] RST_IEN = 8'h00;
  localparam logic [7:0] RST_RDATA = 8'h00;

  // ****************************************************************
  // Control and config fields
  // ****************************************************************
  localparam int CTL_RESET = 7;
  localparam int CTL_LIST_ACCEPT = 5;
  localparam int CTL_KEY_ACCEPT = 4;
  localparam int CTL_DISABLE = 1;
  localparam int CTL_ENABLE = 0;
  localparam int CFG_NEEDS_LOCK = 1;

  // ****************************************************************
  // Status fields
  // ****************************************************************
  localparam int STS_CHAN_ERR = 7;
  localparam int STS_IRQ_PIN = 6;
  localparam int STS_LOCK = 5;
  localparam int STS_HOTPLUG = 4;
  localparam int STS_FOUND = 3;
  localparam int STS_LIST_RDY = 2;
  localparam int STS_KEY_RDY = 1;
  localparam int STS_AUTHENTICATION_DONE = 0;

  // ****************************************************************
  // Interrupt enable and pending fields
  // ****************************************************************
  localparam int IRQ_INDIRECT = 7;
  localparam int IRQ_FOUND = 6;
  localparam int IRQ_DOWNSTREAM = 5;
  localparam int IRQ_KEY_LIST = 4;
  localparam int IRQ_KEY_VECTOR = 3;
  localparam int IRQ_AUTH_FAIL = 2;
  localparam int IRQ_AUTH_PASS = 1;
  localparam int IRQ_GLOBAL = 0;

endpackage : cpsi_pkg

// file: cpsi_status_irq.sv
`timescale 1ns/100ps

module cpsi_status_irq (
  input wire logic core_clk, // Core clock, 100 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic [7:0] reg_addr, // Register address
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  input wire logic [7:0] reg_wdata, // Register write data
  output logic [7:0] reg_rdata, // Register read data
  output logic reg_rvalid, // Read data valid pulse
  input wire logic control_channel_error, // Control channel error pulse
  input wire logic downstream_irq_pin_n, // Downstream interrupt, active low
  input wire logic downstream_lock_seen, // Downstream lock level
  input wire logic downstream_hotplug, // Downstream hot-plug pulse
  input wire logic receiver_found, // Downstream receiver detected level
  input wire logic is_repeater, // Downstream is a repeater
  input wire logic key_list_ready, // Key list loaded pulse
  input wire logic key_vector_ready, // Receiver key read pulse
  input wire logic auth_pass_evt, // Authentication passed pulse
  input wire logic auth_lost_evt, // Authentication failed or lost pulse
  input wire logic indirect_done_evt, // Indirect access done pulse
  output logic protect_enabled, // Content protection enabled
  output logic auth_start, // Start or restart pulse
  output logic auth_stop, // Stop pulse
  output logic auth_hold, // Pause authentication
  output logic irq_out // Interrupt to host, active high
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic wr_cfg;
  logic wr_ctl;
  logic wr_ien;
  logic rd_sts;
  logic rd_isr;

  assign wr_cfg = reg_wr && (reg_addr == cpsi_pkg::ADDR_CFG);
  assign wr_ctl = reg_wr && (reg_addr == cpsi_pkg::ADDR_CTL);
  assign wr_ien = reg_wr && (reg_addr == cpsi_pkg::ADDR_IEN);
  assign rd_sts = reg_rd && (reg_addr == cpsi_pkg::ADDR_STS);
  assign rd_isr = reg_rd && (reg_addr == cpsi_pkg::ADDR_ISR);

  logic enable_wr;
  logic stop_wr;
  logic list_accept_wr;
  logic key_accept_wr;

  assign enable_wr = wr_ctl && reg_wdata[cpsi_pkg::CTL_ENABLE];
  assign stop_wr = wr_ctl && (reg_wdata[cpsi_pkg::CTL_DISABLE] || reg_wdata[cpsi_pkg::CTL_RESET]);
  assign list_accept_wr = wr_ctl && reg_wdata[cpsi_pkg::CTL_LIST_ACCEPT];
  assign key_accept_wr = wr_ctl && reg_wdata[cpsi_pkg::CTL_KEY_ACCEPT];

  // ****************************************************************
  // Enable and restart
  // ****************************************************************
  logic protect_en_q;
  logic auth_start_q;
  logic auth_stop_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      protect_en_q <= 1'b0;
      auth_start_q <= 1'b0;
      auth_stop_q <= 1'b0;
    end else begin
      auth_start_q <= enable_wr;
      auth_stop_q <= stop_wr && !enable_wr;
      if (enable_wr) begin
        protect_en_q <= 1'b1;
      end else if (stop_wr) begin
        protect_en_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Config and interrupt enable registers
  // ****************************************************************
  logic needs_lock_q;
  logic [7:0] ien_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      needs_lock_q <= 1'b0;
    end else if (wr_cfg) begin
      needs_lock_q <= reg_wdata[cpsi_pkg::CFG_NEEDS_LOCK];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ien_q <= cpsi_pkg::RST_IEN;
    end else if (wr_ien) begin
      ien_q <= reg_wdata;
    end
  end

  // ****************************************************************
  // Link status levels
  // ****************************************************************
  logic irq_pin_q;
  logic lock_q;
  logic found_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_pin_q <= 1'b1;
      lock_q <= 1'b0;
      found_q <= 1'b0;
    end else begin
      irq_pin_q <= downstream_irq_pin_n;
      lock_q <= downstream_lock_seen;
      found_q <= receiver_found;
    end
  end

  // ****************************************************************
  // Sticky status, cleared on status read; set wins
  // ****************************************************************
  logic err_q;
  logic hotplug_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      err_q <= 1'b0;
    end else if (control_channel_error) begin
      err_q <= 1'b1;
    end else if (rd_sts) begin
      err_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      hotplug_q <= 1'b0;
    end else if (downstream_hotplug) begin
      hotplug_q <= 1'b1;
    end else if (rd_sts) begin
      hotplug_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Key handshakes and authentication state
  // ****************************************************************
  logic list_rdy_q;
  logic key_rdy_q;
  logic authentication_done_q;
  logic hold_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      list_rdy_q <= 1'b0;
    end else if (key_list_ready) begin
      list_rdy_q <= 1'b1;
    end else if (list_accept_wr) begin
      list_rdy_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      key_rdy_q <= 1'b0;
    end else if (key_vector_ready) begin
      key_rdy_q <= 1'b1;
    end else if (key_accept_wr) begin
      key_rdy_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      authentication_done_q <= 1'b0;
    end else if (auth_pass_evt) begin
      authentication_done_q <= 1'b1;
    end else if (auth_lost_evt || enable_wr || stop_wr) begin
      authentication_done_q <= 1'b0;
    end
  end

  // Repeater pauses on list; non-repeater pauses on receiver key
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hold_q <= 1'b0;
    end else begin
      hold_q <= list_rdy_q || (key_rdy_q && !is_repeater);
    end
  end

  // ****************************************************************
  // Interrupt conditions
  // ****************************************************************
  cpsi_irq_if irq_bus ();

  logic found_cond;
  assign found_cond = found_q && (!needs_lock_q || lock_q);

  assign irq_bus.cond[cpsi_pkg::IRQ_INDIRECT] = indirect_done_evt;
  assign irq_bus.cond[cpsi_pkg::IRQ_FOUND] = found_cond;
  assign irq_bus.cond[cpsi_pkg::IRQ_DOWNSTREAM] = !irq_pin_q;
  assign irq_bus.cond[cpsi_pkg::IRQ_KEY_LIST] = key_list_ready;
  assign irq_bus.cond[cpsi_pkg::IRQ_KEY_VECTOR] = key_vector_ready;
  assign irq_bus.cond[cpsi_pkg::IRQ_AUTH_FAIL] = auth_lost_evt;
  assign irq_bus.cond[cpsi_pkg::IRQ_AUTH_PASS] = auth_pass_evt;
  assign irq_bus.enable = ien_q;
  assign irq_bus.clear = rd_isr;

  cpsi_irq_bank u_bank (
    .core_clk(core_clk),
    .srst(srst),
    .ib(irq_bus.bank)
  );

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [7:0] sts_val;
  logic [7:0] rd_mux;
  logic [7:0] rdata_q;
  logic rvalid_q;

  assign sts_val = {err_q, irq_pin_q, lock_q, hotplug_q, found_q, list_rdy_q, key_rdy_q,
                    authentication_done_q};

  always_comb begin
    rd_mux = cpsi_pkg::RST_RDATA;
    unique case (reg_addr)
      cpsi_pkg::ADDR_CFG: begin
        rd_mux[cpsi_pkg::CFG_NEEDS_LOCK] = needs_lock_q;
      end
      cpsi_pkg::ADDR_CTL: begin
        rd_mux[cpsi_pkg::CTL_ENABLE] = protect_en_q;
      end
      cpsi_pkg::ADDR_STS: begin
        rd_mux = sts_val;
      end
      cpsi_pkg::ADDR_IEN: begin
        rd_mux = ien_q;
      end
      cpsi_pkg::ADDR_ISR: begin
        rd_mux = {irq_bus.pending, |irq_bus.pending};
      end
      default: begin
        rd_mux = cpsi_pkg::RST_RDATA;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_q <= cpsi_pkg::RST_RDATA;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
      if (reg_rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign protect_enabled = protect_en_q;
  assign auth_start = auth_start_q;
  assign auth_stop = auth_stop_q;
  assign auth_hold = hold_q;
  assign irq_out = irq_bus.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  a_enable_start: assert property (
    enable_wr |=> auth_start && protect_enabled ##1 !auth_start)
    else $error("enable write did not start authentication");

  a_zero_write: assert property (
    wr_ctl && !reg_wdata[cpsi_pkg::CTL_ENABLE] && !stop_wr |=> $stable(protect_enabled))
    else $error("zero write changed enable");

  a_err_clear: assert property (
    rd_sts && !control_channel_error |=> !err_q)
    else $error("channel error not cleared by read");

  a_pin_mirror: assert property (
    rd_sts |=> reg_rdata[cpsi_pkg::STS_IRQ_PIN] == $past(downstream_irq_pin_n, 2))
    else $error("status bit6 does not mirror pin");

  a_hotplug_set: assert property (
    downstream_hotplug |=> hotplug_q)
    else $error("hot-plug event lost");

  a_list_hold: assert property (
    key_list_ready |-> ##2 auth_hold)
    else $error("key list ready did not pause authentication");

  a_list_release: assert property (
    list_accept_wr && !key_list_ready |=> !list_rdy_q)
    else $error("list accept did not clear list ready");

  a_key_release: assert property (
    key_accept_wr && !key_vector_ready |=> !key_rdy_q)
    else $error("key accept did not clear key ready");

  a_auth_drop: assert property (
    authentication_done_q && (auth_lost_evt || enable_wr) && !auth_pass_evt |=> !authentication_done_q)
    else $error("authenticated not cleared on loss or restart");

  a_found_lock: assert property (
    irq_bus.pending[cpsi_pkg::IRQ_FOUND] && !$past(irq_bus.pending[cpsi_pkg::IRQ_FOUND])
      |-> $past(receiver_found, 2) && (!$past(needs_lock_q) || $past(downstream_lock_seen, 2)))
    else $error("receiver-found raised without lock");

  c_restart: cover property (protect_enabled && enable_wr ##1 auth_start);
  c_irq_out: cover property (irq_out ##[1:20] rd_isr);
  c_repeater_pause: cover property (auth_hold && is_repeater ##[1:50] list_accept_wr);
  c_authentication_done: cover property (auth_start ##[1:100] authentication_done_q);

endmodule : cpsi_status_irq
